/* rtl/lsic_consts.svh */
`ifndef LSIC_CONSTS_SVH
`define LSIC_CONSTS_SVH

// Register offsets (byte addresses on the register port)
`define LSIC_REG_CTRL 8'h00
`define LSIC_REG_LO_CFG 8'h04
`define LSIC_REG_HI_CFG 8'h08
`define LSIC_REG_STATUS 8'h0c

// Control register fields
`define LSIC_CTRL_SUB_LO 0
`define LSIC_CTRL_SUB_HI 1
`define LSIC_CTRL_WARM_LO 4
`define LSIC_CTRL_WARM_HI 5
`define LSIC_CTRL_STOP_LO 8
`define LSIC_CTRL_STOP_HI 9

// Link configuration fields: width 0 = 8 bit, 1 = 16 bit; freq 0 = 200 MHz
`define LSIC_CFG_W 5
`define LSIC_CFG_WOUT 0
`define LSIC_CFG_WIN 1
`define LSIC_CFG_FREQ_LSB 2
`define LSIC_CFG_FREQ_MSB 4
`define LSIC_CFG_RST 5'h00

// Status register fields
`define LSIC_ST_LO_INIT 0
`define LSIC_ST_HI_INIT 1
`define LSIC_ST_SPLIT 2
`define LSIC_ST_LO_MASTER 3
`define LSIC_ST_HI_MASTER 4
`define LSIC_ST_LO_REQ 5
`define LSIC_ST_HI_REQ 6
`define LSIC_ST_LO_ACT_LSB 8
`define LSIC_ST_HI_ACT_LSB 16

// Timing
`define LSIC_MCLK_PS 5000
`define LSIC_RST_HOLD_NS 1000
`define LSIC_HOLD_CYCLES ((`LSIC_RST_HOLD_NS * 1000 + `LSIC_MCLK_PS - 1) / `LSIC_MCLK_PS)
`define LSIC_TXCLK_BASE_HALF 16

`endif

/* rtl/lsic_pkg.sv */
package lsic_pkg;

    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_reset = 5'b00010,
        st_train = 5'b00100,
        st_active = 5'b01000,
        st_stop = 5'b10000
    } lsic_state_t;

endpackage : lsic_pkg

/* rtl/lsic_half.sv */
`timescale 1ns/1ps
`include "lsic_consts.svh"
module lsic_half import lsic_pkg::*; #(
    parameter int CNT_W = 8,
    parameter logic [CNT_W-1:0] HOLD_CYCLES = CNT_W'(`LSIC_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic warm_req,
    input wire logic stop_req,
    input wire logic [`LSIC_CFG_W-1:0] cfg,
    // Synchronised sideband and lane levels
    input wire logic pg_s,
    input wire logic rst_n_s,
    input wire logic stop_n_s,
    input wire logic rx_clk_edge,
    input wire logic rx_ctl_s,
    // Sideband drive values
    output logic pg_out,
    output logic rst_out,
    output logic stop_out,
    // Link state
    output logic link_up,
    output logic train_ctl,
    output logic tx_clk,
    output logic [`LSIC_CFG_W-1:0] act_cfg
);

    lsic_state_t state;
    lsic_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [7:0] div_cnt;
    logic clk_seen;

    wire hold_done = (cnt == '0);
    wire far_reset = ~rst_n_s | ~pg_s;
    wire entering = (next_state != state);
    wire [7:0] half_period = 8'(`LSIC_TXCLK_BASE_HALF) >> act_cfg[`LSIC_CFG_FREQ_MSB:`LSIC_CFG_FREQ_LSB];
    wire [7:0] div_top = (half_period == 8'h00) ? 8'h00 : half_period - 8'h01;
    wire clk_run = (state == st_train) || (state == st_active);

    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (start) next_state = st_reset;
            end
            st_reset: begin
                if (hold_done && !far_reset) next_state = st_train;
            end
            st_train, st_active: begin
                if (warm_req || far_reset) next_state = st_reset;
                else if (stop_req || !stop_n_s) next_state = st_stop;
                else if (state == st_train && rx_ctl_s && clk_seen) next_state = st_active;
            end
            st_stop: begin
                if (far_reset) next_state = st_reset;
                else if (hold_done && stop_n_s) next_state = st_train;
            end
            default: next_state = st_idle;
        endcase
        if (!start) next_state = st_idle;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= st_idle;
            cnt <= '0;
            clk_seen <= 1'b0;
        end else begin
            state <= next_state;
            if (entering && (next_state == st_reset || next_state == st_stop)) cnt <= HOLD_CYCLES;
            else if (!hold_done) cnt <= cnt - 1'b1;
            clk_seen <= (state == st_train) && (clk_seen || rx_clk_edge);
        end
    end

    // New width and frequency only take hold on entry to training
    always_ff @(posedge mclk) begin
        if (!rstn) act_cfg <= `LSIC_CFG_RST;
        else if (entering && next_state == st_train) act_cfg <= cfg;
    end

    always_ff @(posedge mclk) begin
        if (!rstn || !clk_run) begin
            div_cnt <= 8'h00;
            tx_clk <= 1'b0;
        end else if (div_cnt >= div_top) begin
            div_cnt <= 8'h00;
            tx_clk <= ~tx_clk;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign pg_out = (state != st_idle);
    assign rst_out = ~((state == st_idle) || (state == st_reset && !hold_done));
    assign stop_out = ~(state == st_stop && !hold_done);
    assign link_up = (state == st_active);
    assign train_ctl = (state == st_train) || (state == st_active);

endmodule : lsic_half

/* rtl/lsic_top.sv */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "lsic_consts.svh"
module lsic_top import lsic_pkg::*; #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Straps
    input wire logic split_link_strap,
    input wire logic lower_half_master_strap,
    input wire logic upper_half_master_strap,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Lower sideband
    input wire logic lower_power_good_in,
    output logic lower_power_good_out,
    output logic lower_power_good_oe,
    input wire logic lower_link_reset_n_in,
    output logic lower_link_reset_n_out,
    output logic lower_link_reset_n_oe,
    input wire logic lower_link_stop_n_in,
    output logic lower_link_stop_n_out,
    output logic lower_link_stop_n_oe,
    input wire logic lower_link_request_n,
    // Upper sideband
    input wire logic upper_power_good_in,
    output logic upper_power_good_out,
    output logic upper_power_good_oe,
    input wire logic upper_link_reset_n_in,
    output logic upper_link_reset_n_out,
    output logic upper_link_reset_n_oe,
    input wire logic upper_link_stop_n_in,
    output logic upper_link_stop_n_out,
    output logic upper_link_stop_n_oe,
    input wire logic upper_link_request_n,
    // Link lanes
    input wire logic [1:0] rx_clk,
    input wire logic [1:0] rx_ctl,
    input wire logic [15:0] rx_cad,
    output logic [1:0] tx_clk,
    output logic [1:0] tx_ctl,
    output logic [15:0] tx_cad,
    // User lane data
    input wire logic [1:0] usr_tx_ctl,
    input wire logic [15:0] usr_tx_cad,
    output logic [15:0] usr_rx_cad,
    // Outbound requests
    input wire logic req_valid,
    input wire logic req_addr40,
    output logic req_ready,
    output logic req_go_lower,
    output logic req_go_upper,
    output logic req_bridge,
    // Inbound requests
    input wire logic in_valid,
    input wire logic in_upper,
    input wire logic in_hit,
    output logic in_accept,
    output logic in_forward,
    output logic in_bad
);

    localparam int PIN_W = 31;

    // Clamp a configuration to 8-bit width where 16 is not possible
    function automatic logic [`LSIC_CFG_W-1:0] lsic_limit(input logic [`LSIC_CFG_W-1:0] c, input logic allow16);
        logic [`LSIC_CFG_W-1:0] r;
        r = c;
        r[`LSIC_CFG_WOUT] = c[`LSIC_CFG_WOUT] & allow16;
        r[`LSIC_CFG_WIN] = c[`LSIC_CFG_WIN] & allow16;
        return r;
    endfunction : lsic_limit

    // Pin synchronisers
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [1:0] rx_clk_q;

    wire [PIN_W-1:0] pin_raw = {split_link_strap, lower_half_master_strap, upper_half_master_strap,
                                lower_power_good_in, lower_link_reset_n_in, lower_link_stop_n_in,
                                lower_link_request_n,
                                upper_power_good_in, upper_link_reset_n_in, upper_link_stop_n_in,
                                upper_link_request_n,
                                rx_clk, rx_ctl, rx_cad};

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) rx_clk_q <= 2'h0;
        else rx_clk_q <= pin_s2[19:18];
    end

    wire split_s = pin_s2[30];
    wire lo_master_s = pin_s2[29];
    wire hi_master_s = pin_s2[28];
    wire lo_pg_s = pin_s2[27];
    wire lo_rst_n_s = pin_s2[26];
    wire lo_stop_n_s = pin_s2[25];
    wire lo_req_n_s = pin_s2[24];
    wire hi_pg_s = pin_s2[23];
    wire hi_rst_n_s = pin_s2[22];
    wire hi_stop_n_s = pin_s2[21];
    wire hi_req_n_s = pin_s2[20];
    wire [1:0] rx_clk_s = pin_s2[19:18];
    wire [1:0] rx_ctl_s = pin_s2[17:16];
    wire [15:0] rx_cad_s = pin_s2[15:0];
    wire [1:0] rx_clk_edge = rx_clk_s ^ rx_clk_q;

    // Strap capture: synchronisers must fill before the straps are trusted
    logic [1:0] boot_cnt;
    logic split;
    logic lo_master;
    logic hi_master;
    logic [1:0] sub_role;

    wire boot_done = (boot_cnt == 2'h3);
    wire boot_take = (boot_cnt == 2'h2);

    // Register decode
    wire sel_ctrl = (reg_addr == `LSIC_REG_CTRL);
    wire sel_lo = (reg_addr == `LSIC_REG_LO_CFG);
    wire sel_hi = (reg_addr == `LSIC_REG_HI_CFG);
    wire sel_st = (reg_addr == `LSIC_REG_STATUS);
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire warm_lo = wr_ctrl && reg_wdata[`LSIC_CTRL_WARM_LO];
    wire warm_hi = wr_ctrl && reg_wdata[`LSIC_CTRL_WARM_HI];
    wire stop_lo = wr_ctrl && reg_wdata[`LSIC_CTRL_STOP_LO];
    wire stop_hi = wr_ctrl && reg_wdata[`LSIC_CTRL_STOP_HI];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            boot_cnt <= 2'h0;
            split <= 1'b0;
            lo_master <= 1'b0;
            hi_master <= 1'b0;
        end else begin
            if (!boot_done) boot_cnt <= boot_cnt + 2'h1;
            if (boot_take) begin
                split <= split_s;
                lo_master <= lo_master_s;
                hi_master <= hi_master_s;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) sub_role <= 2'h0;
        else if (boot_take) sub_role <= {~hi_master_s, ~lo_master_s};
        else if (wr_ctrl) sub_role <= {reg_wdata[`LSIC_CTRL_SUB_HI], reg_wdata[`LSIC_CTRL_SUB_LO]};
    end

    // Programmed link settings; cold reset returns both to the minimum
    logic [`LSIC_CFG_W-1:0] lo_cfg;
    logic [`LSIC_CFG_W-1:0] hi_cfg;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lo_cfg <= `LSIC_CFG_RST;
            hi_cfg <= `LSIC_CFG_RST;
        end else if (reg_wr) begin
            if (sel_lo) lo_cfg <= reg_wdata[`LSIC_CFG_W-1:0];
            if (sel_hi) hi_cfg <= reg_wdata[`LSIC_CFG_W-1:0];
        end
    end

    // Half controllers
    logic lo_pg_o;
    logic lo_rst_o;
    logic lo_stop_o;
    logic lo_up;
    logic lo_train;
    logic lo_tclk;
    logic [`LSIC_CFG_W-1:0] lo_act;
    logic hi_pg_o;
    logic hi_rst_o;
    logic hi_stop_o;
    logic hi_up;
    logic hi_train;
    logic hi_tclk;
    logic [`LSIC_CFG_W-1:0] hi_act;

    // Unsplit, the lower half owns both clock lanes
    wire lo_clk_edge = rx_clk_edge[0] | (~split & rx_clk_edge[1]);
    wire hi_start = boot_done & split;

    lsic_half #(.CNT_W(CNT_W)) u_lower (
        .mclk(mclk),
        .rstn(rstn),
        .start(boot_done),
        .warm_req(warm_lo),
        .stop_req(stop_lo),
        .cfg(lsic_limit(lo_cfg, ~split)),
        .pg_s(lo_pg_s),
        .rst_n_s(lo_rst_n_s),
        .stop_n_s(lo_stop_n_s),
        .rx_clk_edge(lo_clk_edge),
        .rx_ctl_s(rx_ctl_s[0]),
        .pg_out(lo_pg_o),
        .rst_out(lo_rst_o),
        .stop_out(lo_stop_o),
        .link_up(lo_up),
        .train_ctl(lo_train),
        .tx_clk(lo_tclk),
        .act_cfg(lo_act)
    );

    lsic_half #(.CNT_W(CNT_W)) u_upper (
        .mclk(mclk),
        .rstn(rstn),
        .start(hi_start),
        .warm_req(warm_hi),
        .stop_req(stop_hi),
        .cfg(lsic_limit(hi_cfg, 1'b0)),
        .pg_s(hi_pg_s),
        .rst_n_s(hi_rst_n_s),
        .stop_n_s(hi_stop_n_s),
        .rx_clk_edge(rx_clk_edge[1]),
        .rx_ctl_s(rx_ctl_s[1]),
        .pg_out(hi_pg_o),
        .rst_out(hi_rst_o),
        .stop_out(hi_stop_o),
        .link_up(hi_up),
        .train_ctl(hi_train),
        .tx_clk(hi_tclk),
        .act_cfg(hi_act)
    );

    // Sideband pins: masters drive and still read back, the upper master only when split; slaves only listen
    wire lo_drive = lo_master;
    wire hi_drive = hi_master & split;

    assign lower_power_good_out = lo_pg_o;
    assign lower_link_reset_n_out = lo_rst_o;
    assign lower_link_stop_n_out = lo_stop_o;
    assign lower_power_good_oe = lo_drive;
    assign lower_link_reset_n_oe = lo_drive;
    assign lower_link_stop_n_oe = lo_drive;
    assign upper_power_good_out = hi_pg_o;
    assign upper_link_reset_n_out = hi_rst_o;
    assign upper_link_stop_n_out = hi_stop_o;
    assign upper_power_good_oe = hi_drive;
    assign upper_link_reset_n_oe = hi_drive;
    assign upper_link_stop_n_oe = hi_drive;

    // Lane routing
    wire lo_wide_out = ~split & lo_act[`LSIC_CFG_WOUT];
    wire lo_wide_in = ~split & lo_act[`LSIC_CFG_WIN];
    wire [7:0] next_tx_lo = lo_up ? usr_tx_cad[7:0] : 8'h00;
    wire [7:0] next_tx_hi = split ? (hi_up ? usr_tx_cad[15:8] : 8'h00)
                                  : ((lo_up & lo_wide_out) ? usr_tx_cad[15:8] : 8'h00);
    wire next_ctl0 = lo_up ? usr_tx_ctl[0] : lo_train;
    wire next_ctl1 = split & (hi_up ? usr_tx_ctl[1] : hi_train);
    wire [7:0] next_rx_lo = lo_up ? rx_cad_s[7:0] : 8'h00;
    wire [7:0] next_rx_hi = split ? (hi_up ? rx_cad_s[15:8] : 8'h00)
                                  : ((lo_up & lo_wide_in) ? rx_cad_s[15:8] : 8'h00);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_cad <= 16'h0000;
            tx_ctl <= 2'h0;
            tx_clk <= 2'h0;
            usr_rx_cad <= 16'h0000;
        end else begin
            tx_cad <= {next_tx_hi, next_tx_lo};
            tx_ctl <= {next_ctl1, next_ctl0};
            tx_clk <= {split ? hi_tclk : lo_tclk, lo_tclk};
            usr_rx_cad <= {next_rx_hi, next_rx_lo};
        end
    end

    // Outbound requests: bit 40 picks the half in split mode
    wire req_upper = req_addr40;
    wire req_tgt_up = req_upper ? (split & hi_up) : lo_up;
    wire req_take = req_valid & req_tgt_up;
    assign req_ready = req_tgt_up;

    // Inbound requests: a window miss is forwarded or refused per role
    wire in_sub = in_upper ? sub_role[1] : sub_role[0];
    wire in_ok = in_upper ? (split & hi_up) : lo_up;
    wire in_take = in_valid & in_ok;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            req_go_lower <= 1'b0;
            req_go_upper <= 1'b0;
            req_bridge <= 1'b0;
            in_accept <= 1'b0;
            in_forward <= 1'b0;
            in_bad <= 1'b0;
        end else begin
            req_go_lower <= req_take & ~req_upper;
            req_go_upper <= req_take & req_upper;
            if (req_take) req_bridge <= ~(req_upper ? sub_role[1] : sub_role[0]);
            in_accept <= in_take & in_hit;
            in_forward <= in_take & ~in_hit & ~in_sub;
            in_bad <= in_take & ~in_hit & in_sub;
        end
    end

    // Register read
    wire [7:0] lo_status = {3'h0, lo_act};
    wire [7:0] hi_status = {3'h0, hi_act};
    wire [31:0] ctrl_rd = {30'h0, sub_role};
    wire [31:0] status_rd = {8'h00, hi_status, lo_status, 1'b0,
                             ~hi_req_n_s & split, ~lo_req_n_s,
                             hi_master, lo_master, split,
                             hi_up, lo_up};
    wire [31:0] next_rdata = sel_ctrl ? ctrl_rd
                           : sel_lo ? {27'h0, lo_cfg}
                           : sel_hi ? {27'h0, hi_cfg}
                           : sel_st ? status_rd
                           : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rstn) reg_rdata <= 32'h0000_0000;
        else if (reg_rd) reg_rdata <= next_rdata;
        else reg_rdata <= 32'h0000_0000;
    end

endmodule : lsic_top

/* test/lsic_monitor.sv */
`timescale 1ns/1ps
module lsic_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Straps
    input wire logic split_link_strap,
    input wire logic upper_half_master_strap,
    // Register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Sideband
    input wire logic lower_power_good_oe,
    input wire logic lower_link_reset_n_oe,
    input wire logic lower_link_stop_n_oe,
    input wire logic lower_link_reset_n_out,
    input wire logic upper_power_good_oe,
    input wire logic upper_link_reset_n_oe,
    input wire logic upper_link_stop_n_oe,
    // Lanes and requests
    input wire logic [1:0] tx_ctl,
    input wire logic req_valid,
    input wire logic req_addr40,
    input wire logic req_ready,
    input wire logic req_go_lower,
    input wire logic req_go_upper,
    input wire logic in_valid,
    input wire logic in_hit,
    input wire logic in_accept,
    input wire logic in_forward,
    input wire logic in_bad
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Cycles the lower reset line has stayed low, saturating
    logic [7:0] low_cnt;
    always_ff @(posedge mclk) begin
        if (!rstn || lower_link_reset_n_out)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hff)
            low_cnt <= low_cnt + 8'h01;
    end

    lo_oe_group_a: assert property (lower_power_good_oe |-> lower_link_reset_n_oe && lower_link_stop_n_oe)
        else $error("lower sideband enables disagree");
    hi_oe_split_a: assert property (upper_power_good_oe |-> upper_link_reset_n_oe && upper_link_stop_n_oe
        && $past(split_link_strap, 8) && $past(upper_half_master_strap, 8)) else $error("upper sideband driven");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    go_lower_a: assert property (req_go_lower |-> $past(req_valid && req_ready && !req_addr40) && !req_go_upper)
        else $error("lower go without lower request");
    go_upper_a: assert property (req_go_upper |-> $past(req_valid && req_ready && req_addr40 && split_link_strap))
        else $error("upper go without upper request");
    miss_forward_a: assert property (in_forward |-> $past(in_valid && !in_hit) && !in_bad && !in_accept)
        else $error("forward without a miss");
    miss_bad_a: assert property (in_bad |-> $past(in_valid && !in_hit) && !in_accept)
        else $error("bad response without a miss");
    ctl_unused_a: assert property (!split_link_strap && !$past(split_link_strap, 8) |-> tx_ctl[1] == 1'b0)
        else $error("control lane one driven while joined");
    reset_hold_a: assert property ($rose(lower_link_reset_n_out) |-> low_cnt >= 8'hc8)
        else $error("lower link reset released early");
endmodule : lsic_monitor

bind lsic_top lsic_monitor u_mon (.mclk, .rstn, .split_link_strap, .upper_half_master_strap, .reg_rd, .reg_rdata,
    .lower_power_good_oe, .lower_link_reset_n_oe, .lower_link_stop_n_oe, .lower_link_reset_n_out,
    .upper_power_good_oe, .upper_link_reset_n_oe, .upper_link_stop_n_oe, .tx_ctl, .req_valid, .req_addr40,
    .req_ready, .req_go_lower, .req_go_upper, .in_valid, .in_hit, .in_accept, .in_forward, .in_bad);

/* test/lsic_far_end.sv */
`timescale 1ns/1ps
module lsic_far_end (
    // Reset seen by the far device
    input wire logic rstn,
    // Lanes from the block
    input wire logic [1:0] tx_ctl,
    input wire logic [15:0] tx_cad,
    // Sideband drive values
    output logic far_pg,
    output logic far_rst_n,
    output logic far_stop_n,
    // Lanes to the block
    output logic [1:0] rx_clk,
    output logic [1:0] rx_ctl,
    output logic [15:0] rx_cad
);
    // Sideband comes up a while after reset, as a real far end would
    always begin
        far_pg = 1'b0;
        far_rst_n = 1'b0;
        wait (rstn === 1'b1);
        #300;
        far_pg = 1'b1;
        far_rst_n = 1'b1;
        wait (rstn === 1'b0);
    end
    assign far_stop_n = 1'b1;

    // Link clock runs only while that lane is framed, 48 ns period
    always #24 rx_clk <= (rx_clk ^ tx_ctl) & tx_ctl;

    // Echo at the width the block drives, but rx_clk keeps its 48 ns period at any programmed rate
    assign #30 rx_ctl = tx_ctl;
    assign rx_cad = tx_ctl[0] ? tx_cad : ~tx_cad;
endmodule : lsic_far_end

/* test/lsic_top_bench.sv */
`timescale 1ns/1ps
`include "lsic_consts.svh"
module lsic_top_bench;
    logic mclk, rstn, split_link_strap, lower_half_master_strap, upper_half_master_strap;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, far_pg, far_rst_n, far_stop_n, lower_link_request_n, upper_link_request_n;
    logic lower_power_good_out, lower_power_good_oe, lower_link_reset_n_out, lower_link_reset_n_oe;
    logic lower_link_stop_n_out, lower_link_stop_n_oe, upper_power_good_out, upper_power_good_oe;
    logic upper_link_reset_n_out, upper_link_reset_n_oe, upper_link_stop_n_out, upper_link_stop_n_oe;
    logic [1:0] rx_clk, rx_ctl, tx_clk, tx_ctl, usr_tx_ctl;
    logic [15:0] rx_cad, tx_cad, usr_tx_cad, usr_rx_cad;
    logic req_valid, req_addr40, req_ready, req_go_lower, req_go_upper, req_bridge;
    logic in_valid, in_upper, in_hit, in_accept, in_forward, in_bad;
    int err_count, n_checks;
    // Pin level: whoever enables wins, otherwise the far end drives
    wire logic lower_power_good_in = lower_power_good_oe ? lower_power_good_out : far_pg;
    wire logic lower_link_reset_n_in = lower_link_reset_n_oe ? lower_link_reset_n_out : far_rst_n;
    wire logic lower_link_stop_n_in = lower_link_stop_n_oe ? lower_link_stop_n_out : far_stop_n;
    wire logic upper_power_good_in = upper_power_good_oe ? upper_power_good_out : far_pg;
    wire logic upper_link_reset_n_in = upper_link_reset_n_oe ? upper_link_reset_n_out : far_rst_n;
    wire logic upper_link_stop_n_in = upper_link_stop_n_oe ? upper_link_stop_n_out : far_stop_n;

    lsic_top #(.CNT_W(8)) u_dut (.mclk, .rstn, .split_link_strap, .lower_half_master_strap,
        .upper_half_master_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .lower_power_good_in, .lower_power_good_out, .lower_power_good_oe, .lower_link_reset_n_in,
        .lower_link_reset_n_out, .lower_link_reset_n_oe, .lower_link_stop_n_in, .lower_link_stop_n_out,
        .lower_link_stop_n_oe, .lower_link_request_n, .upper_power_good_in, .upper_power_good_out,
        .upper_power_good_oe, .upper_link_reset_n_in, .upper_link_reset_n_out, .upper_link_reset_n_oe,
        .upper_link_stop_n_in, .upper_link_stop_n_out, .upper_link_stop_n_oe, .upper_link_request_n,
        .rx_clk, .rx_ctl, .rx_cad, .tx_clk, .tx_ctl, .tx_cad, .usr_tx_ctl, .usr_tx_cad, .usr_rx_cad,
        .req_valid, .req_addr40, .req_ready, .req_go_lower, .req_go_upper, .req_bridge,
        .in_valid, .in_upper, .in_hit, .in_accept, .in_forward, .in_bad);

    lsic_far_end u_far (.rstn, .tx_ctl, .tx_cad, .far_pg, .far_rst_n, .far_stop_n, .rx_clk, .rx_ctl, .rx_cad);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic time_out();
        err_count++;
        stop_test();
    endtask : time_out

    task automatic do_reset(input logic s, input logic lo, input logic hi);
        @(posedge mclk);
        rstn <= 1'b0;
        split_link_strap <= s;
        lower_half_master_strap <= lo;
        upper_half_master_strap <= hi;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
    endtask : do_reset

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : reg_read

    task automatic wait_init(input logic [1:0] m);
        int i;
        logic [31:0] v;
        for (i = 0; i < 1000; i++) begin
            reg_read(`LSIC_REG_STATUS, v);
            if ((v[1:0] & m) === m) break;
        end
        if (i == 1000) time_out();
    endtask : wait_init

    // Expected triple is go_lower, go_upper, bridge
    task automatic send_req(input logic hi, input logic [2:0] exp);
        int i;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_addr40 <= hi;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        if (i == 50) time_out();
        #1;
        check({req_go_lower, req_go_upper, req_bridge}, exp);
    endtask : send_req

    // Expected triple is accept, forward, bad
    task automatic send_in(input logic up, input logic hit, input logic [2:0] exp);
        @(posedge mclk);
        in_valid <= 1'b1;
        in_upper <= up;
        in_hit <= hit;
        @(posedge mclk);
        in_valid <= 1'b0;
        #1;
        check({in_accept, in_forward, in_bad}, exp);
    endtask : send_in

    initial begin
        rstn = 1'b0;
        {split_link_strap, lower_half_master_strap, upper_half_master_strap} = 3'b110;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {lower_link_request_n, upper_link_request_n} = 2'b00;
        usr_tx_ctl = 2'b11;
        usr_tx_cad = 16'ha5c3;
        {req_valid, req_addr40, in_valid, in_upper, in_hit} = 5'h00;
        err_count = 0;
        n_checks = 0;
        // Split link, lower half master, upper half subordinate
        do_reset(1'b1, 1'b1, 1'b0);
        check({lower_power_good_oe, upper_power_good_oe}, 2'b10);
        reg_read(`LSIC_REG_CTRL, d);
        check(d[1:0], 2'b10);
        wait_init(2'b11);
        reg_read(`LSIC_REG_STATUS, d);
        check(d[6:0], 7'h6f);
        check({d[20:16], d[12:8]}, 10'h000);
        send_req(1'b0, 3'b101);
        send_req(1'b1, 3'b010);
        send_in(1'b0, 1'b0, 3'b010);
        send_in(1'b1, 1'b0, 3'b001);
        send_in(1'b1, 1'b1, 3'b100);
        reg_read(8'h10, d);
        check(d, 32'h0000_0000);
        reg_write(`LSIC_REG_LO_CFG, 32'h0000_0004);
        reg_read(`LSIC_REG_LO_CFG, d);
        check(d, 32'h0000_0004);
        reg_write(`LSIC_REG_CTRL, 32'h0000_0012);
        wait_init(2'b01);
        reg_read(`LSIC_REG_STATUS, d);
        check(d[12:8], 5'h04);
        reg_write(`LSIC_REG_CTRL, 32'h0000_0003);
        send_in(1'b0, 1'b0, 3'b001);
        send_req(1'b0, 3'b100);
        reg_write(`LSIC_REG_LO_CFG, 32'h0000_0008);
        reg_write(`LSIC_REG_CTRL, 32'h0000_0103);
        wait_init(2'b01);
        reg_read(`LSIC_REG_STATUS, d);
        check(d[12:8], 5'h08);
        // Joined link, lower half subordinate, upper strap high but unused
        do_reset(1'b0, 1'b0, 1'b1);
        check({lower_power_good_oe, upper_power_good_oe}, 2'b00);
        reg_read(`LSIC_REG_CTRL, d);
        check(d[1:0], 2'b01);
        wait_init(2'b01);
        reg_read(`LSIC_REG_STATUS, d);
        check(d[6:0], 7'h31);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_addr40 <= 1'b1;
        repeat (4) begin
            @(posedge mclk);
            check(req_ready, 1'b0);
        end
        req_valid <= 1'b0;
        reg_write(`LSIC_REG_LO_CFG, 32'h0000_0003);
        reg_write(`LSIC_REG_CTRL, 32'h0000_0011);
        wait_init(2'b01);
        reg_read(`LSIC_REG_STATUS, d);
        check(d[12:8], 5'h03);
        repeat (10) @(posedge mclk);
        #1;
        check(usr_rx_cad, 16'ha5c3);
        check(tx_ctl, 2'b01);
        stop_test();
    end
endmodule : lsic_top_bench
